// [shared/ccr_defs.svh]
// Register indices, field positions, reset values of the control bank.
// Assumes a 32-bit word per register; byte address is four times index.
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

`define CCR_IDX_CONFIG_CONTROL_ZERO 5'h05
`define CCR_IDX_MASK 5'h06
`define CCR_IDX_CONFIG_CONTROL_ONE 5'h0a
`define CCR_IDX_STATE 5'h0b

`define CCR_ADDR_CONFIG_CONTROL_ZERO ({`CCR_IDX_CONFIG_CONTROL_ZERO, 2'h0})
`define CCR_ADDR_MASK ({`CCR_IDX_MASK, 2'h0})
`define CCR_ADDR_CONFIG_CONTROL_ONE ({`CCR_IDX_CONFIG_CONTROL_ONE, 2'h0})
`define CCR_ADDR_STATE ({`CCR_IDX_STATE, 2'h0})

`define CCR_BIT_KEY 31
`define CCR_BIT_IPORT 30
`define CCR_BIT_OVERHEAT 12
`define CCR_BIT_FALLBACK 10
`define CCR_BIT_CELLMASK 8
`define CCR_BIT_FRAME_ADDRESS_SOURCE 7
`define CCR_BIT_DEC 6
`define CCR_BIT_SEC_HI 5
`define CCR_BIT_SEC_LO 4
`define CCR_BIT_PERSIST 3
`define CCR_BIT_GTS 0

`define CCR_SEC_OPEN 2'h0
`define CCR_SEC_NO_READ 2'h1

`define CCR_CONFIG_CONTROL_ZERO_RST 32'h00000481
`define CCR_CONFIG_CONTROL_ZERO_WMASK 32'hc00015f9
`define CCR_MASK_RST 32'hffffffff
`define CCR_CONFIG_CONTROL_ONE_RST 32'h00000000

`endif

// [shared/ccr_pkg.sv]
// Types carried between the control bank and its surroundings.
// Assumes the defines header is included by users of field positions.
package ccr_pkg;

  // One access from the configuration packet path
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [31:0] data;
    logic internal;
    logic encrypted;
  } ccr_req_t;

  // Levels and values sensed from the configuration logic
  typedef struct packed {
    logic end_of_startup;
    logic cfgTristateN;
    logic overheat;
    logic configFailed;
    logic encEnd;
    logic [23:0] eccErrAddr;
    logic [23:0] crcAddr;
  } ccr_sense_t;

  // Control outputs toward the device
  typedef struct packed {
    logic keySource;
    logic internalPortSelect;
    logic overheatShutdown;
    logic fallbackRequest;
    logic haltRequest;
    logic readbackCellMaskN;
    logic [23:0] frameAddr;
    logic decryptorEnable;
    logic [1:0] securityLevel;
    logic readbackBlock;
    logic writeBlock;
    logic interfacePersist;
    logic ioHighZ;
    logic pullupOff;
  } ccr_out_t;

  typedef struct packed {
    logic [31:0] config_control_zero;
    logic [31:0] mask;
    logic [31:0] config_control_one;
    logic keySel;
    logic keyLocked;
    logic [1:0] secLevel;
    logic [31:0] rdData;
    ccr_out_t out;
  } ccr_state_t;

endpackage : ccr_pkg

// [rtl/ccr_ctrl.sv]
// Masked configuration control bank: control zero, mask, control one.
// Assumes accesses arrive as synchronous one-cycle strobes; read data
// follows one cycle after the read strobe.
//
// Operation
// - Writes to control zero change only bits enabled by the mask.
// - The mask filters writes to control one the same way.
// - Bit 31 picks key source: 0 battery-backed, 1 fuse.
// - Key source is frozen once decryptor enable becomes set.
// - Bit 30 picks internal access port: 0 top, 1 bottom.
// - Bit 12 set enables over-temperature power down.
// - Bit 10 clear allows fallback on failure; set stops instead.
// - Bit 8 low masks changeable cell readback; high returns them.
// - Bit 7 picks frame address output: error frame or readback CRC.
// - Bit 6 set enables the bitstream decryptor.
// - Bits 5:4 security: 00 open, 01 no readback, 1x no access.
// - Security limits the external port only, not the internal one.
// - New security level applies at encrypted end or after startup.
// - At levels 00 and 01 external writes reach the bank only when not encrypted.
// - Bit 3 set keeps the mode-selected interface after configuration.
// - Bit 0 low tristates user I/Os; high lets them run.
// - User and configuration tristate both asserted turn pull-ups off.
// - Configuration tristate low puts all user I/Os in high impedance.
// - End-of-startup reads 0 until startup finishes, then 1.
`timescale 1ns/100ps
`include "ccr_defs.svh"

module ccr_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input ccr_pkg::ccr_req_t req,
  input ccr_pkg::ccr_sense_t sense,
  output logic [31:0] regRdData,
  output ccr_pkg::ccr_out_t ctrlOut
);
  import ccr_pkg::*;

  ccr_state_t st;
  ccr_state_t next_st;
  logic extAccess;
  logic wrOk;
  logic rdOk;

  // Merge written data under a mask
  function automatic logic [31:0] maskedWrite(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [31:0] en
  );
    maskedWrite = (oldVal & ~en) | (newVal & en);
  endfunction : maskedWrite

  // Address compare used by write and read decode
  function automatic logic hit(
    input logic [6:0] addr,
    input logic [6:0] target
  );
    hit = (addr == target);
  endfunction : hit

  always_comb begin
    next_st = st;
    extAccess = !req.internal;
    // external writes stopped at level 1x
    wrOk = req.wr && (!extAccess ||
           (!st.secLevel[1] && !req.encrypted));
    // external reads only at open level
    rdOk = req.rd && (!extAccess || (st.secLevel == `CCR_SEC_OPEN));

    if (wrOk) begin
      if (hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ZERO)) begin
        next_st.config_control_zero = maskedWrite(st.config_control_zero, req.data,
                                   st.mask & `CCR_CONFIG_CONTROL_ZERO_WMASK);
      end else if (hit(req.addr, `CCR_ADDR_MASK)) begin
        next_st.mask = req.data;
      end else if (hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ONE)) begin
        next_st.config_control_one = maskedWrite(st.config_control_one, req.data, st.mask);
      end
    end

    next_st.rdData = 32'h00000000;
    if (rdOk) begin
      if (hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ZERO)) begin
        next_st.rdData = st.config_control_zero;
      end else if (hit(req.addr, `CCR_ADDR_MASK)) begin
        next_st.rdData = st.mask;
      end else if (hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ONE)) begin
        next_st.rdData = st.config_control_one;
      end else if (hit(req.addr, `CCR_ADDR_STATE)) begin
        next_st.rdData = {26'h0000000, st.keyLocked, st.keySel,
                          st.secLevel, sense.end_of_startup, sense.cfgTristateN};
      end
    end

    // key source freezes when decryptor is enabled
    if (!st.keyLocked) begin
      next_st.keySel = next_st.config_control_zero[`CCR_BIT_KEY];
      if (next_st.config_control_zero[`CCR_BIT_DEC] && !st.config_control_zero[`CCR_BIT_DEC]) begin
        next_st.keyLocked = 1'b1;
      end
    end

    // level applies at encrypted end or after startup
    if (st.config_control_zero[`CCR_BIT_DEC] ? sense.encEnd : sense.end_of_startup) begin
      next_st.secLevel = st.config_control_zero[`CCR_BIT_SEC_HI:`CCR_BIT_SEC_LO];
    end

    next_st.out.keySource = st.keySel;
    next_st.out.internalPortSelect = st.config_control_zero[`CCR_BIT_IPORT];
    next_st.out.overheatShutdown = st.config_control_zero[`CCR_BIT_OVERHEAT] &&
                                   sense.overheat;
    next_st.out.fallbackRequest = sense.configFailed &&
                                  !st.config_control_zero[`CCR_BIT_FALLBACK];
    next_st.out.haltRequest = sense.configFailed &&
                              st.config_control_zero[`CCR_BIT_FALLBACK];
    next_st.out.readbackCellMaskN = st.config_control_zero[`CCR_BIT_CELLMASK];
    next_st.out.frameAddr = st.config_control_zero[`CCR_BIT_FRAME_ADDRESS_SOURCE] ? sense.crcAddr :
                            sense.eccErrAddr;
    next_st.out.decryptorEnable = st.config_control_zero[`CCR_BIT_DEC];
    next_st.out.securityLevel = st.secLevel;
    next_st.out.readbackBlock = (st.secLevel != `CCR_SEC_OPEN);
    next_st.out.writeBlock = st.secLevel[1];
    next_st.out.interfacePersist = st.config_control_zero[`CCR_BIT_PERSIST];
    next_st.out.ioHighZ = !st.config_control_zero[`CCR_BIT_GTS] || !sense.cfgTristateN;
    next_st.out.pullupOff = !st.config_control_zero[`CCR_BIT_GTS] &&
                            !sense.cfgTristateN;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.config_control_zero <= `CCR_CONFIG_CONTROL_ZERO_RST;
      st.mask <= `CCR_MASK_RST;
      st.config_control_one <= `CCR_CONFIG_CONTROL_ONE_RST;
      st.keySel <= 1'b0;
      st.keyLocked <= 1'b0;
      st.secLevel <= `CCR_SEC_OPEN;
      st.rdData <= 32'h00000000;
      st.out.keySource <= 1'b0;
      st.out.internalPortSelect <= 1'b0;
      st.out.overheatShutdown <= 1'b0;
      st.out.fallbackRequest <= 1'b0;
      st.out.haltRequest <= 1'b0;
      st.out.readbackCellMaskN <= 1'b0;
      st.out.frameAddr <= 24'h000000;
      st.out.decryptorEnable <= 1'b0;
      st.out.securityLevel <= `CCR_SEC_OPEN;
      st.out.readbackBlock <= 1'b0;
      st.out.writeBlock <= 1'b0;
      st.out.interfacePersist <= 1'b0;
      st.out.ioHighZ <= 1'b0;
      st.out.pullupOff <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign regRdData = st.rdData;
  assign ctrlOut = st.out;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // unmasked bits of control zero hold
  mask_hold_a: assert property (
    req.wr && hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ZERO) |=>
      ((st.config_control_zero & ~$past(st.mask)) ==
       ($past(st.config_control_zero) & ~$past(st.mask))))
    else $error("control zero changed outside mask");

  // enabled bits take written value on internal write
  mask_take_a: assert property (
    req.wr && req.internal && hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ZERO) |=>
      ((st.config_control_zero & $past(st.mask) & `CCR_CONFIG_CONTROL_ZERO_WMASK) ==
       ($past(req.data) & $past(st.mask) & `CCR_CONFIG_CONTROL_ZERO_WMASK)))
    else $error("enabled bit missed written value");

  config_control_one_mask_a: assert property (
    req.wr && hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ONE) |=>
      ((st.config_control_one & ~$past(st.mask)) ==
       ($past(st.config_control_one) & ~$past(st.mask))))
    else $error("control one changed outside mask");

  key_freeze_a: assert property (
    st.keyLocked ##1 st.keyLocked |=> $stable(ctrlOut.keySource))
    else $error("key source changed after lock");

  reserved_bits_a: assert property (
    (st.config_control_zero & ~`CCR_CONFIG_CONTROL_ZERO_WMASK) == (`CCR_CONFIG_CONTROL_ZERO_RST & ~`CCR_CONFIG_CONTROL_ZERO_WMASK))
    else $error("reserved control bits changed");

  sec_apply_a: assert property (
    !st.config_control_zero[`CCR_BIT_DEC] && sense.end_of_startup |=> ##1
      (ctrlOut.securityLevel ==
       $past(st.config_control_zero[`CCR_BIT_SEC_HI:`CCR_BIT_SEC_LO], 2)))
    else $error("security level not applied");

  // external write refused at top level
  write_block_a: assert property (
    req.wr && !req.internal && st.secLevel[1] |=>
      $stable(st.config_control_zero) && $stable(st.mask) && $stable(st.config_control_one))
    else $error("external write accepted while blocked");

  enc_write_a: assert property (
    req.wr && req.encrypted && !req.internal |=>
      $stable(st.config_control_zero) && $stable(st.mask))
    else $error("encrypted write reached control bank");

  // read blocked only on external port
  read_block_a: assert property (
    req.rd && !req.internal && (st.secLevel != `CCR_SEC_OPEN) |=>
      (regRdData == 32'h00000000))
    else $error("external read not blocked");

  read_data_a: assert property (
    req.rd && req.internal && hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ZERO) |=>
      (regRdData == $past(st.config_control_zero)))
    else $error("internal read of control zero wrong");

  pullup_off_a: assert property (
    !st.config_control_zero[`CCR_BIT_GTS] && !sense.cfgTristateN |=>
      ctrlOut.pullupOff && ctrlOut.ioHighZ)
    else $error("pull-ups not turned off");

  cfg_highz_a: assert property (
    !sense.cfgTristateN |=> ctrlOut.ioHighZ)
    else $error("I/Os not high impedance");

  frame_src_a: assert property (
    st.config_control_zero[`CCR_BIT_FRAME_ADDRESS_SOURCE] |=> (ctrlOut.frameAddr == $past(sense.crcAddr)))
    else $error("frame address source wrong");

  // written key bit reaches the output while unlocked
  key_source_a: assert property (
    req.wr && req.internal && hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ZERO) &&
    st.mask[`CCR_BIT_KEY] && !st.keyLocked |=> ##1
      (ctrlOut.keySource == $past(req.data[`CCR_BIT_KEY], 2)))
    else $error("key source does not follow written bit");

  // lock captures the stored key bit
  key_latch_a: assert property (
    $rose(st.keyLocked) |->
      (st.config_control_zero[`CCR_BIT_DEC] && (st.keySel == st.config_control_zero[`CCR_BIT_KEY])))
    else $error("key source not latched with decryptor enable");

  // shutdown only when enabled and hot
  overheat_on_a: assert property (
    st.config_control_zero[`CCR_BIT_OVERHEAT] && sense.overheat |=>
      ctrlOut.overheatShutdown)
    else $error("over-temperature shutdown missed");

  overheat_off_a: assert property (
    !st.config_control_zero[`CCR_BIT_OVERHEAT] |=> !ctrlOut.overheatShutdown)
    else $error("over-temperature shutdown while disabled");

  // failure leads to fallback or halt
  fallback_req_a: assert property (
    sense.configFailed && !st.config_control_zero[`CCR_BIT_FALLBACK] |=>
      ctrlOut.fallbackRequest && !ctrlOut.haltRequest)
    else $error("fallback not requested");

  halt_req_a: assert property (
    sense.configFailed && st.config_control_zero[`CCR_BIT_FALLBACK] |=>
      ctrlOut.haltRequest && !ctrlOut.fallbackRequest)
    else $error("halt not requested");

  cell_mask_a: assert property (
    1'b1 |=> (ctrlOut.readbackCellMaskN ==
              $past(st.config_control_zero[`CCR_BIT_CELLMASK])))
    else $error("readback cell mask wrong");

  // error frame address when source bit clear
  frame_ecc_a: assert property (
    !st.config_control_zero[`CCR_BIT_FRAME_ADDRESS_SOURCE] |=>
      (ctrlOut.frameAddr == $past(sense.eccErrAddr)))
    else $error("error frame address not selected");

  dec_enable_a: assert property (
    1'b1 |=> (ctrlOut.decryptorEnable == $past(st.config_control_zero[`CCR_BIT_DEC])))
    else $error("decryptor enable wrong");

  sec_limits_a: assert property (
    1'b1 |=>
      (ctrlOut.readbackBlock == ($past(st.secLevel) != `CCR_SEC_OPEN)) &&
      (ctrlOut.writeBlock == $past(st.secLevel[1])))
    else $error("security limits wrong");

  // external plain write accepted below top level
  ext_write_a: assert property (
    req.wr && !req.internal && !req.encrypted && !st.secLevel[1] &&
    hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ZERO) |=>
      ((st.config_control_zero & $past(st.mask) & `CCR_CONFIG_CONTROL_ZERO_WMASK) ==
       ($past(req.data) & $past(st.mask) & `CCR_CONFIG_CONTROL_ZERO_WMASK)))
    else $error("permitted external write lost");

  enc_apply_a: assert property (
    st.config_control_zero[`CCR_BIT_DEC] && sense.encEnd |=> ##1
      (ctrlOut.securityLevel ==
       $past(st.config_control_zero[`CCR_BIT_SEC_HI:`CCR_BIT_SEC_LO], 2)))
    else $error("security level not applied at encrypted end");

  sec_hold_a: assert property (
    !(st.config_control_zero[`CCR_BIT_DEC] ? sense.encEnd : sense.end_of_startup) |=>
      $stable(st.secLevel))
    else $error("security level changed without its event");

  user_tristate_a: assert property (
    !st.config_control_zero[`CCR_BIT_GTS] |=> ctrlOut.ioHighZ)
    else $error("user tristate ignored");

  io_active_a: assert property (
    st.config_control_zero[`CCR_BIT_GTS] && sense.cfgTristateN |=>
      !ctrlOut.ioHighZ && !ctrlOut.pullupOff)
    else $error("I/Os held off while released");

  state_read_a: assert property (
    req.rd && req.internal && hit(req.addr, `CCR_ADDR_STATE) |=>
      (regRdData[1:0] == {$past(sense.end_of_startup), $past(sense.cfgTristateN)}))
    else $error("state word wrong");

  key_lock_c: cover property (!st.keyLocked ##1 st.keyLocked);
  enc_end_c: cover property (st.config_control_zero[`CCR_BIT_DEC] && sense.encEnd);
  sec_raise_c: cover property (ctrlOut.writeBlock);
  partial_write_c: cover property (
    req.wr && hit(req.addr, `CCR_ADDR_CONFIG_CONTROL_ZERO) && (st.mask != 32'hffffffff));
  tristate_c: cover property (ctrlOut.pullupOff);

endmodule : ccr_ctrl

// [bench/tb_top.sv]
// Self-checking bench for the masked control bank, with a register model.
// Assumes ccr_pkg is compiled first and ccr_defs.svh is on the include path.
`timescale 1ns/100ps
`include "ccr_defs.svh"

module tb_top;
  import ccr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ccr_req_t req = '0;
  ccr_sense_t sense = '{end_of_startup: 1'b1, cfgTristateN: 1'b1, default: '0};
  logic [31:0] regRdData;
  ccr_out_t ctrlOut;
  int nMismatch = 0;
  int totalChecks = 0;
  int cycles = 0;
  logic [31:0] mCtl0 = `CCR_CONFIG_CONTROL_ZERO_RST;
  logic [31:0] mMask = `CCR_MASK_RST;
  logic [31:0] mCtl1 = `CCR_CONFIG_CONTROL_ONE_RST;
  logic [1:0] mSec = 2'h0;
  logic mKey = 1'b0;
  logic mLock = 1'b0;

  ccr_ctrl i_ccr_ctrl (
    .clk(clk),
    .rst_n(rst_n),
    .req(req),
    .sense(sense),
    .regRdData(regRdData),
    .ctrlOut(ctrlOut)
  );

  always #2 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      nMismatch++;
      stop_test();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Expected control outputs from the model state
  function automatic ccr_out_t expOut();
    logic [31:0] c;
    logic t;
    c = mCtl0;
    t = sense.cfgTristateN;
    return '{mKey, c[30], c[12] & sense.overheat,
      sense.configFailed & !c[10], sense.configFailed & c[10], c[8],
      c[7] ? sense.crcAddr : sense.eccErrAddr, c[6], mSec, mSec != 2'h0,
      mSec[1], c[3], !c[0] || !t, !c[0] && !t};
  endfunction : expOut

  task automatic wr(input logic [6:0] a, input logic [31:0] d,
                    input logic intl = 1'b1, input logic enc = 1'b0);
    logic [31:0] en;
    logic [31:0] n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d, intl, enc};
    @(posedge clk);
    req <= '0;
    if (!intl && (mSec[1] || enc)) return;
    en = mMask & `CCR_CONFIG_CONTROL_ZERO_WMASK;
    n = (mCtl0 & ~en) | (d & en);
    case (a)
      `CCR_ADDR_CONFIG_CONTROL_ZERO: begin
        if (!mLock) mKey = n[31];
        if (!mCtl0[6] && n[6]) mLock = 1'b1;
        mCtl0 = n;
      end
      `CCR_ADDR_MASK: mMask = d;
      `CCR_ADDR_CONFIG_CONTROL_ONE: mCtl1 = (mCtl1 & ~mMask) | (d & mMask);
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic intl = 1'b1);
    logic [31:0] e;
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 32'h0, intl, 1'b0};
    case (a)
      `CCR_ADDR_CONFIG_CONTROL_ZERO: e = mCtl0;
      `CCR_ADDR_MASK: e = mMask;
      `CCR_ADDR_CONFIG_CONTROL_ONE: e = mCtl1;
      `CCR_ADDR_STATE: e = {26'h0000000, mLock, mKey, mSec, sense.end_of_startup,
                            sense.cfgTristateN};
      default: e = 32'h0;
    endcase
    if (!intl && mSec != 2'h0) e = 32'h0;
    @(posedge clk);
    req <= '0;
    #1 chk(64'(regRdData), 64'(e));
    @(posedge clk);
    #1 chk(64'(regRdData), 64'h0);
  endtask : rd

  // Optional end-of-encryption pulse, then wait and compare outputs
  task automatic settle(input logic pulse = 1'b0);
    @(posedge clk);
    sense.encEnd <= pulse;
    @(posedge clk);
    sense.encEnd <= 1'b0;
    repeat (3) @(posedge clk);
    if (mCtl0[6] ? pulse : sense.end_of_startup) mSec = mCtl0[5:4];
    #1 chk(64'(ctrlOut), 64'(expOut()));
  endtask : settle

  initial begin
    void'($urandom(99));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`CCR_ADDR_CONFIG_CONTROL_ZERO);
    rd(`CCR_ADDR_MASK);
    rd(`CCR_ADDR_CONFIG_CONTROL_ONE);
    settle();
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      sense.overheat <= 1'($urandom);
      sense.configFailed <= 1'($urandom);
      sense.cfgTristateN <= 1'($urandom);
      sense.eccErrAddr <= 24'($urandom);
      sense.crcAddr <= 24'($urandom);
      wr(`CCR_ADDR_MASK, $urandom);
      wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, $urandom & 32'hffffffbf);
      wr(`CCR_ADDR_CONFIG_CONTROL_ONE, $urandom);
      settle();
      rd(`CCR_ADDR_STATE);
      rd(`CCR_ADDR_CONFIG_CONTROL_ZERO);
      rd(`CCR_ADDR_CONFIG_CONTROL_ONE);
    end
    wr(`CCR_ADDR_MASK, 32'hffffffff);
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h00000411);
    settle();
    rd(`CCR_ADDR_CONFIG_CONTROL_ZERO, 1'b0);
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h00000491, 1'b0);
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h00000481, 1'b0, 1'b1);
    settle();
    rd(`CCR_ADDR_CONFIG_CONTROL_ZERO);
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h00000421);
    settle();
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h00000401, 1'b0);
    rd(`CCR_ADDR_CONFIG_CONTROL_ZERO, 1'b0);
    rd(`CCR_ADDR_CONFIG_CONTROL_ZERO);
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h00000401);
    settle();
    @(posedge clk);
    sense.end_of_startup <= 1'b0;
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h00000411);
    settle();
    rd(`CCR_ADDR_STATE);
    @(posedge clk);
    sense.end_of_startup <= 1'b1;
    settle();
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h00000401);
    settle();
    wr(7'h30, 32'h5a5a5a5a);
    rd(7'h30);
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h80000441);
    settle();
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h00000461);
    settle();
    rd(`CCR_ADDR_CONFIG_CONTROL_ZERO);
    settle(1'b1);
    wr(`CCR_ADDR_MASK, 32'h00000001);
    wr(`CCR_ADDR_CONFIG_CONTROL_ZERO, 32'h00000000);
    settle();
    rd(`CCR_ADDR_CONFIG_CONTROL_ZERO);
    stop_test();
  end
endmodule : tb_top
